// ### hw/ptg_pkg.sv
/*
  Constants and types of the packet traffic generator and checker.
  Assumes a 32-bit AXI4-Lite register bus and 32-bit packet streams.
*/
package ptg_pkg;

  // ******************************************
  // Register byte addresses
  // ******************************************
  localparam logic [31:0] ADDR_LOOP  = 32'h44A0_0000;
  localparam logic [31:0] ADDR_GEN   = 32'h44A0_0004;
  localparam logic [31:0] ADDR_CHK   = 32'h44A0_0008;
  localparam logic [31:0] ADDR_GLEN  = 32'h44A0_000C;
  localparam logic [31:0] ADDR_CLEN  = 32'h44A0_0010;
  localparam logic [31:0] ADDR_WRAP  = 32'h44A0_0014;
  localparam logic [31:0] ADDR_RES   = 32'h44A0_0018;
  localparam logic [31:0] ADDR_ISTS  = 32'h44A0_001C;
  localparam logic [31:0] ADDR_ICLR  = 32'h44A0_0020;
  localparam logic [31:0] ADDR_IEN   = 32'h44A0_0024;

  // ******************************************
  // Fields, reset values, bus answers
  // ******************************************
  localparam int          EN_BIT     = 0;
  localparam int          MISS_BIT   = 0;
  localparam int          EV_MISS    = 0;
  localparam int          EV_GDONE   = 1;
  localparam int          EV_CDONE   = 2;
  localparam int          EV_W       = 3;
  localparam logic [31:0] REG_RESET  = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;

  // Register index used by the bus decoder
  typedef enum logic [3:0] {
    RI_LOOP, RI_GEN, RI_CHK, RI_GLEN, RI_CLEN, RI_WRAP,
    RI_RES, RI_ISTS, RI_ICLR, RI_IEN, RI_NONE
  } ptg_ri_t;

  typedef enum logic {
    G_IDLE,
    G_SEND
  } ptg_gst_t;

endpackage : ptg_pkg

// ### hw/ptg_top.sv
/*
  Packet traffic generator, checker and loopback with an AXI4-Lite
  register bank and one level interrupt.
  Assumes one clock, a synchronous reset, and a streaming DMA engine on
  both packet streams running on SYS_CLK.
*/
// What this block does
// - Loopback enable bit 0, reset zero
// - Generator enable bit 0 starts traffic unless looping back
// - Checker enable bit 0 checks incoming traffic
// - 32-bit generated length, packets of it
// - 32-bit expected length checked on receive
// - 32-bit wrap count wraps sequence number
// - Read-only mismatch bit 0, zero after reset
`timescale 1ns/1ns
module ptg_top
  import ptg_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [31:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      M_TDATA,
  output logic             M_TVALID,
  output logic             M_TLAST,
  input  wire logic        M_TREADY,
  input  wire logic [31:0] S_TDATA,
  input  wire logic        S_TVALID,
  input  wire logic        S_TLAST,
  output logic             S_TREADY,
  output logic             IRQ
);

  // ******************************************
  // Helpers
  // ******************************************
  function automatic ptg_ri_t decode(input logic [31:0] a);
    case (a)
      ADDR_LOOP: decode = RI_LOOP;
      ADDR_GEN:  decode = RI_GEN;
      ADDR_CHK:  decode = RI_CHK;
      ADDR_GLEN: decode = RI_GLEN;
      ADDR_CLEN: decode = RI_CLEN;
      ADDR_WRAP: decode = RI_WRAP;
      ADDR_RES:  decode = RI_RES;
      ADDR_ISTS: decode = RI_ISTS;
      ADDR_ICLR: decode = RI_ICLR;
      ADDR_IEN:  decode = RI_IEN;
      default:   decode = RI_NONE;
    endcase
  endfunction : decode

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = st[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
  endfunction : merge

  // Beats in a packet of len bytes, partial word rounds up
  function automatic logic [31:0] beats(input logic [31:0] len);
    logic [32:0] s;
    s = {1'b0, len} + 33'h0_0000_0003;
    beats = {1'b0, s[32:2]};
  endfunction : beats

  function automatic logic [31:0] seq_next(input logic [31:0] s,
                                           input logic [31:0] w);
    seq_next = (s >= w) ? 32'h0 : s + 32'h1;
  endfunction : seq_next

  // ******************************************
  // State
  // ******************************************
  typedef struct packed {
    logic            aw_ok;
    logic [31:0]     awaddr;
    logic            w_ok;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic            loop;
    logic            gen_en;
    logic            chk_en;
    logic [31:0]     gen_len;
    logic [31:0]     chk_len;
    logic [31:0]     wrap;
    logic            miss;
    logic [EV_W-1:0] ists;
    logic [EV_W-1:0] ien;
    logic            irq;
    ptg_gst_t        gst;
    logic [31:0]     gbeat;
    logic [31:0]     gseq;
    logic [31:0]     cbeat;
    logic [31:0]     cseq;
    logic            tvalid;
    logic [31:0]     tdata;
    logic            tlast;
    logic            rx_rdy;
  } ptg_st_t;

  ptg_st_t q;
  ptg_st_t next_q;

  logic    [31:0]   gnb;
  logic    [31:0]   cnb;
  logic             tx_take;
  logic             rx_take;
  logic             do_wr;
  ptg_ri_t          wri;
  ptg_ri_t          rri;
  logic    [31:0]   wval;
  logic    [31:0]   rval;
  logic    [EV_W-1:0] ev;
  logic             bad;

  assign gnb     = beats(q.gen_len);
  assign cnb     = beats(q.chk_len);
  assign tx_take = q.tvalid && M_TREADY;
  assign rx_take = S_TVALID && q.rx_rdy;
  assign do_wr   = q.aw_ok && q.w_ok && !q.bvalid;
  assign wri     = decode(q.awaddr);
  assign rri     = decode(S_AXI_ARADDR);

  always_comb
  begin
    next_q = q;
    ev     = '0;
    bad    = 1'b0;
    wval   = 32'h0;
    rval   = 32'h0;

    // ******************************************
    // AXI4-Lite write: address and data in either order
    // ******************************************
    if (S_AXI_AWVALID && q.awready)
    begin
      next_q.aw_ok  = 1'b1;
      next_q.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && q.wready)
    begin
      next_q.w_ok  = 1'b1;
      next_q.wdata = S_AXI_WDATA;
      next_q.wstrb = S_AXI_WSTRB;
    end
    if (S_AXI_BREADY && q.bvalid)
      next_q.bvalid = 1'b0;
    if (do_wr)
    begin
      next_q.aw_ok  = 1'b0;
      next_q.w_ok   = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp  = RESP_OKAY;
      case (wri)
        RI_LOOP: begin wval = merge(REG_RESET, q.wdata, q.wstrb); next_q.loop = wval[EN_BIT]; end
        RI_GEN:  begin wval = merge(REG_RESET, q.wdata, q.wstrb); next_q.gen_en = wval[EN_BIT]; end
        RI_CHK:  begin wval = merge(REG_RESET, q.wdata, q.wstrb); next_q.chk_en = wval[EN_BIT]; end
        RI_GLEN: next_q.gen_len = merge(q.gen_len, q.wdata, q.wstrb);
        RI_CLEN: next_q.chk_len = merge(q.chk_len, q.wdata, q.wstrb);
        RI_WRAP: next_q.wrap = merge(q.wrap, q.wdata, q.wstrb);
        RI_ICLR: next_q.ists = q.ists & ~q.wdata[EV_W-1:0];
        RI_IEN:  next_q.ien = q.wdata[EV_W-1:0];
        RI_RES, RI_ISTS: ;
        default: next_q.bresp = RESP_SLV;
      endcase
    end
    next_q.awready = !next_q.aw_ok;
    next_q.wready  = !next_q.w_ok;

    // ******************************************
    // AXI4-Lite read, answered one edge after the address
    // ******************************************
    if (S_AXI_RREADY && q.rvalid)
    begin
      next_q.rvalid  = 1'b0;
    end
    if (S_AXI_ARVALID && q.arready)
    begin
      case (rri)
        RI_LOOP: rval[EN_BIT] = q.loop;
        RI_GEN:  rval[EN_BIT] = q.gen_en;
        RI_CHK:  rval[EN_BIT] = q.chk_en;
        RI_GLEN: rval = q.gen_len;
        RI_CLEN: rval = q.chk_len;
        RI_WRAP: rval = q.wrap;
        RI_RES:  rval[MISS_BIT] = q.miss;
        RI_ISTS: rval[EV_W-1:0] = q.ists;
        RI_IEN:  rval[EV_W-1:0] = q.ien;
        RI_ICLR: ;
        default: bad = 1'b1;
      endcase
      next_q.rvalid  = 1'b1;
      next_q.rdata   = rval;
      next_q.rresp   = bad ? RESP_SLV : RESP_OKAY;
    end
    next_q.arready = !next_q.rvalid;

    // ******************************************
    // Transmit slot: generator or loopback
    // ******************************************
    if (tx_take)
      next_q.tvalid = 1'b0;
    case (q.gst)
      G_IDLE:
      begin
        if (!q.gen_en)
          next_q.gseq = 32'h0;
        // New packets start only while enabled and not looping back
        if (q.gen_en && !q.loop && gnb != 32'h0 && !next_q.tvalid)
        begin
          next_q.gst    = G_SEND;
          next_q.gbeat  = 32'h0;
          next_q.tvalid = 1'b1;
          next_q.tdata  = q.gseq;
          next_q.tlast  = (gnb == 32'h1);
        end
        else if (q.loop && rx_take)
        begin
          next_q.tvalid = 1'b1;
          next_q.tdata  = S_TDATA;
          next_q.tlast  = S_TLAST;
        end
      end
      G_SEND:
      begin
        if (tx_take && q.tlast)
        begin
          next_q.gst  = G_IDLE;
          next_q.gseq = seq_next(q.gseq, q.wrap);
          ev[EV_GDONE] = 1'b1;
        end
        else if (tx_take)
        begin
          next_q.gbeat  = q.gbeat + 32'h1;
          next_q.tvalid = 1'b1;
          next_q.tdata  = q.gseq;
          next_q.tlast  = (q.gbeat + 32'h2 >= gnb);
        end
      end
      default: next_q.gst = G_IDLE;
    endcase
    // Loopback holds one beat, so it runs at half rate at best
    next_q.rx_rdy = next_q.loop ? (next_q.gst == G_IDLE && !next_q.tvalid) : 1'b1;

    // ******************************************
    // Checker
    // ******************************************
    if (!q.chk_en)
    begin
      next_q.cbeat = 32'h0;
      next_q.cseq  = 32'h0;
      next_q.miss  = 1'b0;
    end
    else if (rx_take)
    begin
      if (S_TDATA != q.cseq || S_TLAST != (q.cbeat + 32'h1 >= cnb))
      begin
        next_q.miss  = 1'b1;
        ev[EV_MISS]  = !q.miss;
      end
      if (S_TLAST)
      begin
        next_q.cbeat = 32'h0;
        next_q.cseq  = seq_next(q.cseq, q.wrap);
        ev[EV_CDONE] = 1'b1;
      end
      else
        next_q.cbeat = q.cbeat + 32'h1;
    end

    // ******************************************
    // Interrupts: a new event beats a clear in the same cycle
    // ******************************************
    next_q.ists = next_q.ists | ev;
    next_q.irq  = |(next_q.ists & next_q.ien);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      q <= '0;
    else
      q <= next_q;
  end

  assign S_AXI_AWREADY = q.awready;
  assign S_AXI_WREADY  = q.wready;
  assign S_AXI_BVALID  = q.bvalid;
  assign S_AXI_BRESP   = q.bresp;
  assign S_AXI_ARREADY = q.arready;
  assign S_AXI_RVALID  = q.rvalid;
  assign S_AXI_RDATA   = q.rdata;
  assign S_AXI_RRESP   = q.rresp;
  assign M_TVALID      = q.tvalid;
  assign M_TDATA       = q.tdata;
  assign M_TLAST       = q.tlast;
  assign S_TREADY      = q.rx_rdy;
  assign IRQ           = q.irq;

  // ******************************************
  // Assertions
  // ******************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_ctrl_reset_zero: assert property ($fell(RST) |-> !q.loop && !q.gen_en && !q.chk_en && !q.miss)
    else $error("control bits not zero after reset");
  a_gen_off_idle: assert property (!q.gen_en && q.gst == G_IDLE && !q.loop |=> q.gst == G_IDLE)
    else $error("generator started while disabled");
  a_chk_off_quiet: assert property (!q.chk_en |=> !q.miss && q.cseq == 32'h0)
    else $error("checker active while disabled");
  a_tx_hold_beat: assert property (M_TVALID && !M_TREADY |=> M_TVALID && $stable(M_TDATA) && $stable(M_TLAST))
    else $error("transmit beat changed before taken");
  a_gen_last_beat: assert property (q.gst == G_SEND && M_TVALID && M_TLAST |-> q.gbeat + 32'h1 == gnb)
    else $error("generated packet length wrong");
  a_seq_wrap: assert property (q.gst == G_SEND && tx_take && M_TLAST && q.gseq >= q.wrap |=> q.gseq == 32'h0)
    else $error("sequence did not wrap");
  a_gen_seq_data: assert property (q.gst == G_SEND && M_TVALID |-> M_TDATA == q.gseq)
    else $error("generated data not sequence number");
  a_miss_sticky: assert property (q.miss && q.chk_en |=> q.miss)
    else $error("mismatch cleared while checker enabled");
  a_miss_detect: assert property (q.chk_en && rx_take && S_TDATA != q.cseq |=> q.miss [*2])
    else $error("mismatch not reported");
  a_irq_level: assert property (##1 IRQ == |($past(next_q.ists) & $past(next_q.ien)))
    else $error("interrupt level wrong");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read not answered next cycle");

endmodule : ptg_top

// ### tb/ptg_dma_model.sv
/*
  Stream partner of the traffic block: a sink that can throttle its ready
  and records every beat, and a packet source driven by task calls.
  Assumes the block's clock; callers enter send_pkt just after a rising edge.
*/
`timescale 1ns/1ns
module ptg_dma_model
(
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic [31:0] m_tdata,
  input  wire logic        m_tvalid,
  input  wire logic        m_tlast,
  output logic             m_tready,
  output logic [31:0]      s_tdata,
  output logic             s_tvalid,
  output logic             s_tlast,
  input  wire logic        s_tready
);
  // ******************************************
  // Sink and source
  // ******************************************
  logic [32:0] rx_q[$];

  initial
  begin
    m_tready = 1'b1;
    s_tdata  = 32'h0000_0000;
    s_tvalid = 1'b0;
    s_tlast  = 1'b0;
  end

  // Alternating ready under stall exercises held beats
  always @(posedge clk)
  begin
    if (m_tvalid === 1'b1 && m_tready === 1'b1)
      rx_q.push_back({m_tlast, m_tdata});
    m_tready <= stall ? ~m_tready : 1'b1;
  end

  task automatic send_pkt(input logic [31:0] base, input logic [31:0] step, input int beats);
    logic [31:0] d;
    d = base;
    for (int i = 0; i < beats; i++)
    begin
      s_tdata  <= d;
      s_tlast  <= (i == beats - 1);
      s_tvalid <= 1'b1;
      do @(posedge clk); while (s_tready !== 1'b1);
      d = d + step;
    end
    // Released lines show no stale beat
    s_tvalid <= 1'b0;
    s_tdata  <= ~s_tdata;
    s_tlast  <= ~s_tlast;
    @(posedge clk);
  endtask : send_pkt
endmodule : ptg_dma_model

// ### tb/testbench.sv
/*
  Self-checking bench of the traffic generator and checker: register bank
  over AXI4-Lite, generated, checked and looped packets, interrupt.
  Assumes ptg_top and the stream partner ptg_dma_model.
*/
`timescale 1ns/1ns
module testbench
  import ptg_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] REG_ADDR[7] = '{ADDR_LOOP, ADDR_GEN, ADDR_CHK, ADDR_GLEN, ADDR_CLEN, ADDR_WRAP, ADDR_RES};
  logic        SYS_CLK, RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, stall;
  logic        M_TVALID, M_TLAST, M_TREADY, S_TVALID, S_TLAST, S_TREADY, IRQ;
  logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA, M_TDATA, S_TDATA;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  int          mismatches, checks_done;

  ptg_top i_dut
  (
    .SYS_CLK(SYS_CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .M_TDATA(M_TDATA), .M_TVALID(M_TVALID), .M_TLAST(M_TLAST), .M_TREADY(M_TREADY),
    .S_TDATA(S_TDATA), .S_TVALID(S_TVALID), .S_TLAST(S_TLAST), .S_TREADY(S_TREADY), .IRQ(IRQ)
  );

  ptg_dma_model i_dma
  (
    .clk(SYS_CLK), .stall(stall), .m_tdata(M_TDATA), .m_tvalid(M_TVALID), .m_tlast(M_TLAST),
    .m_tready(M_TREADY), .s_tdata(S_TDATA), .s_tvalid(S_TVALID), .s_tlast(S_TLAST), .s_tready(S_TREADY)
  );

  // ******************************************
  // Clock, tasks, watchdog
  // ******************************************
  initial
  begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Ready lines stay high, so each response is taken at its first edge
  task automatic wr(input logic [31:0] addr, input logic [31:0] data, input logic [1:0] exp);
    S_AXI_AWADDR  <= addr;
    S_AXI_WDATA   <= data;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    do
    begin
      @(posedge SYS_CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY === 1'b1)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY === 1'b1)
        S_AXI_WVALID <= 1'b0;
    end
    while (S_AXI_BVALID !== 1'b1);
    check({30'h0, S_AXI_BRESP}, {30'h0, exp});
  endtask : wr

  task automatic rd(input logic [31:0] addr, input logic [31:0] exp, input logic [31:0] mask, input logic [1:0] er);
    S_AXI_ARADDR  <= addr;
    S_AXI_ARVALID <= 1'b1;
    do
    begin
      @(posedge SYS_CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY === 1'b1)
        S_AXI_ARVALID <= 1'b0;
    end
    while (S_AXI_RVALID !== 1'b1);
    check(S_AXI_RDATA & mask, exp);
    check({30'h0, S_AXI_RRESP}, {30'h0, er});
  endtask : rd

  task automatic wait_rx(input int n);
    for (int k = 0; k < 4000 && i_dma.rx_q.size() < n; k++) @(posedge SYS_CLK);
    check({31'h0, i_dma.rx_q.size() >= n}, 32'h1);
  endtask : wait_rx

  task automatic chk_rx(input int i, input logic [31:0] d, input logic l);
    check(i_dma.rx_q[i][31:0], d);
    check({31'h0, i_dma.rx_q[i][32]}, {31'h0, l});
  endtask : chk_rx

  initial
  begin
    repeat (30000) @(posedge SYS_CLK);
    mismatches++;
    report_and_stop();
  end

  // ******************************************
  // Test sequence
  // ******************************************
  initial
  begin
    mismatches    = 0;
    checks_done   = 0;
    RST           = 1'b1;
    stall         = 1'b0;
    S_AXI_AWADDR  = 32'h0;
    S_AXI_WDATA   = 32'h0;
    S_AXI_ARADDR  = 32'h0;
    S_AXI_AWVALID = 1'b0;
    S_AXI_WVALID  = 1'b0;
    S_AXI_ARVALID = 1'b0;
    S_AXI_WSTRB   = 4'hF;
    S_AXI_BREADY  = 1'b1;
    S_AXI_RREADY  = 1'b1;
    repeat (8) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    foreach (REG_ADDR[i]) rd(REG_ADDR[i], REG_RESET, ALL, RESP_OKAY);
    for (int i = 0; i < 3; i++)
    begin
      wr(REG_ADDR[i], ALL, RESP_OKAY);
      rd(REG_ADDR[i], 32'h1, ALL, RESP_OKAY);
      wr(REG_ADDR[i], REG_RESET, RESP_OKAY);
    end
    wr(ADDR_GLEN, 32'h0000_8000, RESP_OKAY);
    rd(ADDR_GLEN, 32'h0000_8000, ALL, RESP_OKAY);
    wr(ADDR_CLEN, 32'hA5C3_5A3C, RESP_OKAY);
    rd(ADDR_CLEN, 32'hA5C3_5A3C, ALL, RESP_OKAY);
    wr(ADDR_WRAP, 32'h5A3C_A5C3, RESP_OKAY);
    rd(ADDR_WRAP, 32'h5A3C_A5C3, ALL, RESP_OKAY);
    wr(ADDR_IEN + 32'h4, ALL, RESP_SLV);
    rd(ADDR_IEN + 32'h4, 32'h0, ALL, RESP_SLV);
    // Two-beat packets under back-pressure, sequence 0 1 2 0
    stall <= 1'b1;
    wr(ADDR_GLEN, 32'h8, RESP_OKAY);
    wr(ADDR_WRAP, 32'h2, RESP_OKAY);
    wr(ADDR_GEN, 32'h1, RESP_OKAY);
    wait_rx(8);
    wr(ADDR_GEN, REG_RESET, RESP_OKAY);
    for (int i = 0; i < 8; i++) chk_rx(i, 32'(i / 2 % 3), i[0]);
    // A packet begun as the enable drops still finishes; let it drain
    repeat (16) @(posedge SYS_CLK);
    i_dma.rx_q.delete();
    wr(ADDR_CLEN, 32'h8, RESP_OKAY);
    wr(ADDR_CHK, 32'h1, RESP_OKAY);
    i_dma.send_pkt(32'h0, 32'h0, 2);
    i_dma.send_pkt(32'h1, 32'h0, 2);
    i_dma.send_pkt(32'h2, 32'h0, 2);
    i_dma.send_pkt(32'h0, 32'h0, 2);
    rd(ADDR_RES, 32'h0, ALL, RESP_OKAY);
    i_dma.send_pkt(32'h5, 32'h0, 2);
    wr(ADDR_RES, REG_RESET, RESP_OKAY);
    rd(ADDR_RES, 32'h1, 32'h1, RESP_OKAY);
    rd(ADDR_ISTS, 32'h1, 32'h1, RESP_OKAY);
    check({31'h0, IRQ}, 32'h0);
    wr(ADDR_IEN, 32'h1, RESP_OKAY);
    repeat (2) @(posedge SYS_CLK);
    check({31'h0, IRQ}, 32'h1);
    i_dma.send_pkt(32'h2, 32'h0, 2);
    rd(ADDR_RES, 32'h1, 32'h1, RESP_OKAY);
    wr(ADDR_ICLR, 32'h1, RESP_OKAY);
    repeat (2) @(posedge SYS_CLK);
    check({31'h0, IRQ}, 32'h0);
    wr(ADDR_CHK, REG_RESET, RESP_OKAY);
    rd(ADDR_RES, 32'h0, 32'h1, RESP_OKAY);
    // Received beats come back unchanged on the transmit stream
    wr(ADDR_LOOP, 32'h1, RESP_OKAY);
    i_dma.send_pkt(32'hA0, 32'h1, 3);
    wait_rx(3);
    for (int i = 0; i < 3; i++) chk_rx(i, 32'(32'hA0 + i), i == 2);
    report_and_stop();
  end
endmodule : testbench
